/* src/ffau_core.sv */
// arithmetic datapath and sequencer of the fixed/float arithmetic unit
`timescale 1ns/1ps
module ffau_core (
	input  wire logic                         ref_clk_i,
	input  wire logic                         sys_rst_i,
	input  wire logic                         start_i,
	input  wire logic [5:0]                   opcode_i,
	input  wire logic                         indirect_i,
	input  wire logic [1:0]                   index_sel_i,
	input  wire logic [ffau_pkg::ADDR_W-1:0]  addr_field_i,
	input  wire logic [ffau_pkg::ADDR_W-1:0]  index1_i,
	input  wire logic [ffau_pkg::ADDR_W-1:0]  index2_i,
	input  wire logic [ffau_pkg::ADDR_W-1:0]  index3_i,
	input  wire logic                         reg_load_a_i,
	input  wire logic                         reg_load_q_i,
	input  wire logic [ffau_pkg::WORD_W-1:0]  reg_load_data_i,
	input  wire logic                         mem_ack_i,
	input  wire logic [ffau_pkg::WORD_W-1:0]  mem_rdata_i,
	input  wire logic                         exp_ovf_set_i,
	input  wire logic                         exp_ovf_sense_i,
	output logic                              mem_req_o,
	output logic                              mem_we_o,
	output logic [ffau_pkg::ADDR_W-1:0]       mem_addr_o,
	output logic [ffau_pkg::WORD_W-1:0]       mem_wdata_o,
	output logic [ffau_pkg::WORD_W-1:0]       a_o,
	output logic [ffau_pkg::WORD_W-1:0]       q_o,
	output logic                              busy_o,
	output logic                              done_o,
	output logic                              trap_o,
	output logic [5:0]                        trap_opcode_o,
	output logic                              div_fault_o,
	output logic                              exp_ovf_o,
	output logic                              exp_ovf_sensed_o
);
	import ffau_pkg::*;

	typedef struct packed {
		ffau_state_t         st;
		logic [5:0]          op;
		logic [ADDR_W-1:0]   ea;
		logic [WORD_W-1:0]   a;
		logic [WORD_W-1:0]   q;
		logic [WORD_W-1:0]   op_hi;
		logic [CNT_W-1:0]    cnt;
		logic [CNT_W-1:0]    need;
		logic                busy;
		logic                done;
		logic                trap;
		logic [5:0]          trap_op;
		logic                fault;
		logic                mreq;
		logic                mwe;
		logic [ADDR_W-1:0]   maddr;
		logic [WORD_W-1:0]   mwdata;
		logic                ovf;
		logic                sensed;
	} ffau_regs_t;

	ffau_regs_t r_q;
	ffau_regs_t r_d;

	//==============================================================
	// helpers
	function automatic logic is_trapped(input logic [5:0] op);
		return (op == OP_DMUL) || (op == OP_DDIV) || ((op >= OP_FADD) && (op <= OP_FDIV));
	endfunction

	function automatic logic is_double(input logic [5:0] op);
		return (op == OP_DADD) || (op == OP_DSUB);
	endfunction

	function automatic logic is_hw(input logic [5:0] op);
		return (op == OP_ADD) || (op == OP_SUB) || (op == OP_RAD) || (op == OP_MUL) ||
			(op == OP_DIV) || is_double(op);
	endfunction

	function automatic logic [CNT_W-1:0] min_cycles(input logic [5:0] op);
		unique case (op)
			OP_MUL:                    return MUL_CYC;
			OP_DIV:                    return DIV_CYC;
			OP_RAD, OP_DADD, OP_DSUB:  return DBL_CYC;
			default:                   return ADD_CYC;
		endcase
	endfunction

	function automatic logic [ADDR_W-1:0] index_of(input logic [1:0] sel);
		unique case (sel)
			2'h1:    return index1_i;
			2'h2:    return index2_i;
			2'h3:    return index3_i;
			default: return '0;
		endcase
	endfunction

	//==============================================================
	// arithmetic
	logic [2*WORD_W-1:0] mul_prod;
	logic [2*WORD_W-1:0] div_quot;
	logic [2*WORD_W-1:0] div_rem;
	logic [2*WORD_W-1:0] dvd;
	logic [2*WORD_W-1:0] dvs;
	logic                div_bad;
	logic [2*WORD_W-1:0] dbl_sum;
	logic [2*WORD_W-1:0] dbl_dif;

	always_comb begin
		dvd      = {r_q.a, r_q.q};
		dvs      = {{WORD_W{mem_rdata_i[WORD_W-1]}}, mem_rdata_i};
		// both factors widened first so the full product survives
		mul_prod = $signed({{WORD_W{r_q.a[WORD_W-1]}}, r_q.a}) * $signed(dvs);
		if (mem_rdata_i == '0) begin
			div_quot = '0;
			div_rem  = '0;
		end else begin
			div_quot = 48'($signed(dvd) / $signed(dvs));
			div_rem  = 48'($signed(dvd) % $signed(dvs));
		end
		// quotient must fit a signed word
		div_bad  = (mem_rdata_i == '0) ||
			(div_quot[2*WORD_W-1:WORD_W-1] != {(WORD_W+1){div_quot[WORD_W-1]}});
		dbl_sum  = {r_q.a, r_q.q} + {r_q.op_hi, mem_rdata_i};
		dbl_dif  = {r_q.a, r_q.q} - {r_q.op_hi, mem_rdata_i};
	end

	//==============================================================
	// sequencer
	always_comb begin
		r_d       = r_q;
		r_d.done  = 1'b0;
		r_d.trap  = 1'b0;
		r_d.fault = 1'b0;
		r_d.sensed = 1'b0;
		r_d.cnt   = r_q.busy ? r_q.cnt + CNT_W'(1) : '0;
		if (reg_load_a_i && !r_q.busy) begin
			r_d.a = reg_load_data_i;
		end
		if (reg_load_q_i && !r_q.busy) begin
			r_d.q = reg_load_data_i;
		end
		unique case (r_q.st)
			S_IDLE: begin
				if (start_i && is_trapped(opcode_i)) begin
					r_d.trap    = 1'b1;
					r_d.trap_op = opcode_i;
					r_d.done    = 1'b1;
				end else if (start_i && is_hw(opcode_i)) begin
					r_d.op    = opcode_i;
					r_d.ea    = addr_field_i + index_of(index_sel_i);
					r_d.need  = min_cycles(opcode_i);
					r_d.busy  = 1'b1;
					r_d.mreq  = 1'b1;
					r_d.mwe   = 1'b0;
					r_d.maddr = addr_field_i + index_of(index_sel_i);
					r_d.st    = indirect_i ? S_IND : S_RD0;
				end
			end
			S_IND: begin
				if (mem_ack_i) begin
					r_d.ea    = mem_rdata_i[ADDR_W-1:0];
					r_d.maddr = mem_rdata_i[ADDR_W-1:0];
					r_d.st    = S_RD0;
				end
			end
			S_RD0: begin
				if (mem_ack_i) begin
					r_d.st = S_WAIT;
					r_d.mreq = 1'b0;
					unique case (r_q.op)
						OP_ADD: r_d.a = r_q.a + mem_rdata_i;
						OP_SUB: r_d.a = r_q.a - mem_rdata_i;
						OP_RAD: begin
							r_d.mreq   = 1'b1;
							r_d.mwe    = 1'b1;
							r_d.mwdata = r_q.a + mem_rdata_i;
							r_d.st     = S_WR;
						end
						OP_MUL: begin
							r_d.q = mul_prod[2*WORD_W-1:WORD_W];
							r_d.a = mul_prod[WORD_W-1:0];
						end
						OP_DIV: begin
							if (div_bad) begin
								r_d.fault = 1'b1;
								r_d.done  = 1'b1;
								r_d.busy  = 1'b0;
								r_d.st    = S_IDLE;
							end else begin
								r_d.a = div_quot[WORD_W-1:0];
								r_d.q = div_rem[WORD_W-1:0];
							end
						end
						default: begin
							r_d.op_hi = mem_rdata_i;
							r_d.mreq  = 1'b1;
							r_d.maddr = r_q.ea + ADDR_W'(1);
							r_d.st    = S_RD1;
						end
					endcase
				end
			end
			S_RD1: begin
				if (mem_ack_i) begin
					r_d.mreq = 1'b0;
					r_d.st   = S_WAIT;
					if (r_q.op == OP_DADD) begin
						{r_d.a, r_d.q} = dbl_sum;
					end else begin
						{r_d.a, r_d.q} = dbl_dif;
					end
				end
			end
			S_WR: begin
				if (mem_ack_i) begin
					r_d.mreq = 1'b0;
					r_d.mwe  = 1'b0;
					r_d.st   = S_WAIT;
				end
			end
			S_WAIT: begin
				// pad to the documented execution time
				if (r_q.cnt >= r_q.need - CNT_W'(1)) begin
					r_d.done = 1'b1;
					r_d.busy = 1'b0;
					r_d.st   = S_IDLE;
				end
			end
		endcase
		// set wins over sense-clear
		if (exp_ovf_sense_i) begin
			r_d.sensed = r_q.ovf;
			r_d.ovf    = 1'b0;
		end
		if (exp_ovf_set_i) begin
			r_d.ovf = 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			r_q <= '{st: S_IDLE, default: '0};
		end else begin
			r_q <= r_d;
		end
	end

	assign mem_req_o        = r_q.mreq;
	assign mem_we_o         = r_q.mwe;
	assign mem_addr_o       = r_q.maddr;
	assign mem_wdata_o      = r_q.mwdata;
	assign a_o              = r_q.a;
	assign q_o              = r_q.q;
	assign busy_o           = r_q.busy;
	assign done_o           = r_q.done;
	assign trap_o           = r_q.trap;
	assign trap_opcode_o    = r_q.trap_op;
	assign div_fault_o      = r_q.fault;
	assign exp_ovf_o        = r_q.ovf;
	assign exp_ovf_sensed_o = r_q.sensed;

	//==============================================================
	// checks
	a_trap_pulse: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(r_q.st == S_IDLE && start_i && is_trapped(opcode_i)) |=> (trap_o && done_o && !busy_o))
		else $error("trapped opcode not handed to software");

	a_add_sum: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(r_q.st == S_RD0 && mem_ack_i && r_q.op == OP_ADD) |=> (a_o == $past(r_q.a + mem_rdata_i)))
		else $error("single add result wrong");

	a_sub_diff: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(r_q.st == S_RD0 && mem_ack_i && r_q.op == OP_SUB) |=> (a_o == $past(r_q.a - mem_rdata_i)))
		else $error("single subtract result wrong");

	a_rad_write: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(r_q.st == S_RD0 && mem_ack_i && r_q.op == OP_RAD) |=>
		(mem_req_o && mem_we_o && mem_addr_o == $past(r_q.ea) &&
		mem_wdata_o == $past(r_q.a + mem_rdata_i) && a_o == $past(r_q.a)))
		else $error("replace add write wrong");

	a_mul_prod: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(r_q.st == S_RD0 && mem_ack_i && r_q.op == OP_MUL) |=>
		($signed({q_o, a_o}) == $past($signed(r_q.a)) * $past($signed(mem_rdata_i))))
		else $error("multiply product wrong");

	a_fault_ends: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		div_fault_o |-> (done_o && !busy_o && r_q.st == S_IDLE))
		else $error("divide fault did not abandon");

	a_dadd_sum: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(r_q.st == S_RD1 && mem_ack_i && r_q.op == OP_DADD) |=>
		({a_o, q_o} == $past({r_q.a, r_q.q} + {r_q.op_hi, mem_rdata_i})))
		else $error("double add result wrong");

	a_latency_min: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(done_o && !div_fault_o && !trap_o) |-> ($past(r_q.cnt) + 1'b1 >= $past(r_q.need)))
		else $error("instruction finished early");

	a_ovf_clear: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(exp_ovf_sense_i && !exp_ovf_set_i) |=> (!exp_ovf_o && exp_ovf_sensed_o == $past(exp_ovf_o)))
		else $error("overflow indicator not cleared by sense");

	a_ea_form: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(r_q.st == S_IDLE && start_i && is_hw(opcode_i) && !indirect_i) |=>
		(mem_req_o && !mem_we_o && mem_addr_o == $past(addr_field_i + index_of(index_sel_i))))
		else $error("effective address wrong");

	a_dsub_diff: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(r_q.st == S_RD1 && mem_ack_i && r_q.op == OP_DSUB) |=>
		({a_o, q_o} == $past({r_q.a, r_q.q} - {r_q.op_hi, mem_rdata_i})))
		else $error("double subtract result wrong");

	a_div_ident: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(r_q.st == S_RD0 && mem_ack_i && r_q.op == OP_DIV) |=>
		(div_fault_o ||
		($signed($past({r_q.a, r_q.q})) == $signed(a_o) * $signed($past(mem_rdata_i)) + $signed(q_o))))
		else $error("divide quotient and remainder inconsistent");

	a_fault_keep: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		div_fault_o |-> ($stable(a_o) && $stable(q_o)))
		else $error("divide fault disturbed registers");

	a_trap_keep: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(r_q.st == S_IDLE && start_i && is_trapped(opcode_i) && !reg_load_a_i && !reg_load_q_i) |=>
		($stable(a_o) && $stable(q_o)))
		else $error("trapped opcode touched registers");

	a_ind_fetch: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(r_q.st == S_IND && mem_ack_i) |=>
		(mem_req_o && !mem_we_o && mem_addr_o == $past(mem_rdata_i[ADDR_W-1:0])))
		else $error("indirect address not followed");

	a_req_hold: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		(mem_req_o && !mem_ack_i) |=>
		(mem_req_o && $stable(mem_addr_o) && $stable(mem_we_o) && $stable(mem_wdata_o)))
		else $error("storage request dropped before answer");

	a_ovf_set: assert property (@(posedge ref_clk_i) disable iff (sys_rst_i)
		exp_ovf_set_i |=> exp_ovf_o)
		else $error("overflow indicator not set");

endmodule // ffau_core

/* common/ffau_pkg.sv */
// constants, opcodes and state types of the fixed/float arithmetic unit
//==============================================================
package ffau_pkg;
	localparam int         WORD_W      = 24;
	localparam int         ADDR_W      = 15;
	localparam int         CNT_W       = 9;
	localparam int         CLK_NS      = 40;
	// opcodes (octal 30,31,32,33,34,50,51,56,57,60..63)
	localparam logic [5:0] OP_ADD      = 6'h18;
	localparam logic [5:0] OP_SUB      = 6'h19;
	localparam logic [5:0] OP_DADD     = 6'h1a;
	localparam logic [5:0] OP_DSUB     = 6'h1b;
	localparam logic [5:0] OP_RAD      = 6'h1c;
	localparam logic [5:0] OP_MUL      = 6'h28;
	localparam logic [5:0] OP_DIV      = 6'h29;
	localparam logic [5:0] OP_DMUL     = 6'h2e;
	localparam logic [5:0] OP_DDIV     = 6'h2f;
	localparam logic [5:0] OP_FADD     = 6'h30;
	localparam logic [5:0] OP_FDIV     = 6'h33;
	// execution times in ns
	localparam int         T_ADD_NS    = 3500;
	localparam int         T_DBL_NS    = 5200;
	localparam int         T_MUL_NS    = 14500;
	localparam int         T_DIV_NS    = 15000;
	localparam logic [CNT_W-1:0] ADD_CYC = CNT_W'((T_ADD_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] DBL_CYC = CNT_W'((T_DBL_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] MUL_CYC = CNT_W'((T_MUL_NS + CLK_NS - 1) / CLK_NS);
	localparam logic [CNT_W-1:0] DIV_CYC = CNT_W'((T_DIV_NS + CLK_NS - 1) / CLK_NS);

	typedef enum logic [2:0] {
		S_IDLE,
		S_IND,
		S_RD0,
		S_RD1,
		S_WR,
		S_WAIT
	} ffau_state_t;
endpackage

/* dv/ffau_mem_model.sv */
// core storage model answering the arithmetic unit's requests
`timescale 1ns/1ps
module ffau_mem_model (
	input  wire logic                        ref_clk_i,
	input  wire logic                        sys_rst_i,
	input  wire logic                        mem_req_i,
	input  wire logic                        mem_we_i,
	input  wire logic [ffau_pkg::ADDR_W-1:0] mem_addr_i,
	input  wire logic [ffau_pkg::WORD_W-1:0] mem_wdata_i,
	input  wire logic [3:0]                  delay_i,
	output logic                             mem_ack_o,
	output logic [ffau_pkg::WORD_W-1:0]      mem_rdata_o
);
	import ffau_pkg::*;
	logic [WORD_W-1:0] mem [0:63];
	logic [3:0]        wait_q;
	// rdata toggles outside ack so stale data never looks valid
	always @(posedge ref_clk_i) begin
		mem_rdata_o <= ~mem_rdata_o;
		mem_ack_o   <= 1'b0;
		if (sys_rst_i) begin
			mem_rdata_o <= 24'h5a5a5a;
			wait_q      <= 4'h0;
		end else if (!mem_req_i || mem_ack_o) begin
			wait_q <= 4'h0;
		end else if (wait_q >= delay_i) begin
			mem_ack_o <= 1'b1;
			if (mem_we_i) begin
				mem[mem_addr_i[5:0]] <= mem_wdata_i;
			end else begin
				mem_rdata_o <= mem[mem_addr_i[5:0]];
			end
		end else begin
			wait_q <= wait_q + 4'h1;
		end
	end
endmodule // ffau_mem_model

/* dv/ffau_core_tb_top.sv */
// self-checking testbench of the fixed/float arithmetic unit
`timescale 1ns/1ps
module ffau_core_tb_top;
	import ffau_pkg::*;
	logic        ref_clk_i = 0, sys_rst_i = 1, start_i = 0, indirect_i = 0;
	logic [5:0]  opcode_i = 0;
	logic [1:0]  index_sel_i = 0;
	logic [14:0] addr_field_i = 0;
	logic        reg_load_a_i = 0, reg_load_q_i = 0, exp_ovf_set_i = 0, exp_ovf_sense_i = 0;
	logic [23:0] reg_load_data_i = 0, mem_rdata_i, mem_wdata_o, a_o, q_o;
	logic        mem_ack_i, mem_req_o, mem_we_o, busy_o, done_o, trap_o, div_fault_o, exp_ovf_o, exp_ovf_sensed_o;
	logic [14:0] mem_addr_o;
	logic [5:0]  trap_opcode_o;
	logic [3:0]  delay = 0;
	logic        fault;
	int          bad_count = 0, comparisons = 0, n;
	logic [5:0]  tops [6] = '{OP_DMUL, OP_DDIV, OP_FADD, 6'h31, 6'h32, OP_FDIV};
	always #20 ref_clk_i = ~ref_clk_i;
	ffau_core ffau_core_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .start_i(start_i), .opcode_i(opcode_i),
		.indirect_i(indirect_i), .index_sel_i(index_sel_i), .addr_field_i(addr_field_i), .index1_i(15'h0003),
		.index2_i(15'h0004), .index3_i(15'h0005), .reg_load_a_i(reg_load_a_i), .reg_load_q_i(reg_load_q_i),
		.reg_load_data_i(reg_load_data_i), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i),
		.exp_ovf_set_i(exp_ovf_set_i), .exp_ovf_sense_i(exp_ovf_sense_i), .mem_req_o(mem_req_o),
		.mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .a_o(a_o), .q_o(q_o),
		.busy_o(busy_o), .done_o(done_o), .trap_o(trap_o), .trap_opcode_o(trap_opcode_o),
		.div_fault_o(div_fault_o), .exp_ovf_o(exp_ovf_o), .exp_ovf_sensed_o(exp_ovf_sensed_o));
	ffau_mem_model ffau_mem_model_i (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .mem_req_i(mem_req_o),
		.mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o), .mem_wdata_i(mem_wdata_o), .delay_i(delay),
		.mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));
	//==============================================================
	// shared tasks
	task automatic end_of_test();
		if (bad_count == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
		comparisons++;
		if (g !== e) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic ld(input logic [23:0] a, input logic [23:0] q);
		reg_load_a_i = 1; reg_load_data_i = a;
		@(posedge ref_clk_i); #1;
		reg_load_a_i = 0; reg_load_q_i = 1; reg_load_data_i = q;
		@(posedge ref_clk_i); #1;
		reg_load_q_i = 0;
	endtask
	// issues one instruction, returns cycles from issue to done
	task automatic run_op(input logic [5:0] op, input logic ind, input logic [1:0] xs, input logic [14:0] m);
		opcode_i = op; indirect_i = ind; index_sel_i = xs; addr_field_i = m; start_i = 1;
		@(posedge ref_clk_i); #1;
		start_i = 0; n = 1;
		while (done_o !== 1'b1 && n < 2000) begin
			@(posedge ref_clk_i); #1;
			n++;
		end
		if (n >= 2000) begin
			bad_count++;
			end_of_test();
		end
		fault = div_fault_o;
	endtask
	//==============================================================
	// scenarios
	task automatic t_add();
		ffau_mem_model_i.mem[13] = 24'h000005;
		ld(24'h7ffffe, 24'h0);
		run_op(OP_ADD, 0, 2'd1, 15'd10);
		chk("add_a", 48'h800003, a_o);
		chk("add_cyc", ADD_CYC + 1, n);
		chk("add_busy", 0, busy_o);
	endtask
	task automatic t_sub_ind();
		delay = 3;
		ffau_mem_model_i.mem[20] = 24'hff001e;
		ffau_mem_model_i.mem[30] = 24'h000007;
		ld(24'h00000a, 24'h0);
		run_op(OP_SUB, 1, 2'd0, 15'd20);
		chk("sub_a", 48'h3, a_o);
		delay = 0;
	endtask
	task automatic t_rad();
		ffau_mem_model_i.mem[50] = 24'h00000a;
		ld(24'h000005, 24'h0);
		run_op(OP_RAD, 0, 2'd3, 15'd45);
		chk("rad_mem", 48'hf, ffau_mem_model_i.mem[50]);
		chk("rad_a", 48'h5, a_o);
		chk("rad_cyc", DBL_CYC + 1, n);
	endtask
	task automatic t_mul();
		ffau_mem_model_i.mem[51] = 24'h000005;
		ffau_mem_model_i.mem[52] = 24'h800000;
		ld(24'hfffffd, 24'h0);
		run_op(OP_MUL, 0, 2'd0, 15'd51);
		chk("mul_qa", 48'hfffffffffff1, {q_o, a_o});
		chk("mul_cyc", MUL_CYC + 1, n);
		ld(24'h800000, 24'h0);
		run_op(OP_MUL, 0, 2'd0, 15'd52);
		chk("mul_qa", 48'h400000000000, {q_o, a_o});
	endtask
	task automatic t_div();
		ffau_mem_model_i.mem[53] = 24'h000007;
		ffau_mem_model_i.mem[54] = 24'h000000;
		ld(24'h0, 24'h000064);
		run_op(OP_DIV, 0, 2'd0, 15'd53);
		chk("div_aq", 48'h00000e000002, {a_o, q_o});
		chk("div_cyc", DIV_CYC + 1, n);
		chk("div_flt", 0, fault);
		ld(24'hffffff, 24'hffff9c);
		run_op(OP_DIV, 0, 2'd0, 15'd53);
		chk("div_aq", 48'hfffff2fffffe, {a_o, q_o});
		run_op(OP_DIV, 0, 2'd0, 15'd54);
		chk("div_flt", 1, fault);
	endtask
	task automatic t_dbl();
		ffau_mem_model_i.mem[40] = 24'h000000;
		ffau_mem_model_i.mem[41] = 24'h000001;
		ld(24'h000001, 24'hffffff);
		run_op(OP_DADD, 0, 2'd2, 15'd36);
		chk("dadd_aq", 48'h000002000000, {a_o, q_o});
		chk("dadd_cyc", DBL_CYC + 1, n);
		run_op(OP_DSUB, 0, 2'd0, 15'd40);
		chk("dsub_aq", 48'h000001ffffff, {a_o, q_o});
	endtask
	task automatic t_trap();
		foreach (tops[k]) begin
			run_op(tops[k], 0, 2'd0, 15'd0);
			chk("trap_cyc", 1, n);
			chk("trap", 1, trap_o);
			chk("trap_op", tops[k], trap_opcode_o);
			@(posedge ref_clk_i); #1;
		end
	endtask
	task automatic t_ovf();
		exp_ovf_set_i = 1;
		@(posedge ref_clk_i); #1;
		exp_ovf_set_i = 0; exp_ovf_sense_i = 1;
		chk("ovf", 1, exp_ovf_o);
		@(posedge ref_clk_i); #1;
		chk("ovf", 0, exp_ovf_o);
		chk("sensed", 1, exp_ovf_sensed_o);
		exp_ovf_set_i = 1;
		@(posedge ref_clk_i); #1;
		exp_ovf_set_i = 0; exp_ovf_sense_i = 0;
		chk("ovf", 1, exp_ovf_o);
		chk("sensed", 0, exp_ovf_sensed_o);
	endtask
	//==============================================================
	// main sequence
	initial begin
		repeat (4) @(posedge ref_clk_i);
		#1;
		sys_rst_i = 0;
		chk("rst_a", 0, a_o);
		t_add();
		t_sub_ind();
		t_rad();
		t_mul();
		t_div();
		t_dbl();
		t_trap();
		t_ovf();
		end_of_test();
	end
endmodule // ffau_core_tb_top
